// File: hdl/tcc_pin_edge.sv
// external count pin synchroniser and edge detector
module tcc_pin_edge (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pin and detected edges
    input wire logic pin,
    output logic rise,
    output logic fall
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign rise = sync_r & ~prev_r;
    assign fall = ~sync_r & prev_r;

endmodule : tcc_pin_edge

// File: hdl/tcc_pkg.sv
// constants, types and helpers for the timer clock and counter core
package tcc_pkg;

    // register byte offsets (one aligned word each, data in bits 7:0)
    localparam logic [7:0] TCC_OFF_CTRL_A = 8'h00;
    localparam logic [7:0] TCC_OFF_CTRL_B = 8'h04;
    localparam logic [7:0] TCC_OFF_COUNT_LO = 8'h08;
    localparam logic [7:0] TCC_OFF_COUNT_HI = 8'h0C;
    localparam logic [7:0] TCC_OFF_CMPA_LO = 8'h10;
    localparam logic [7:0] TCC_OFF_CMPA_HI = 8'h14;
    localparam logic [7:0] TCC_OFF_CMPB_LO = 8'h18;
    localparam logic [7:0] TCC_OFF_CMPB_HI = 8'h1C;
    localparam logic [7:0] TCC_OFF_CAPT_LO = 8'h20;
    localparam logic [7:0] TCC_OFF_CAPT_HI = 8'h24;
    localparam logic [7:0] TCC_OFF_FLAGS = 8'h28;
    localparam logic [7:0] TCC_OFF_PRESCALE = 8'h2C;

    // field positions
    localparam int TCC_WGM_LO_POS = 0;
    localparam int TCC_CS_POS = 0;
    localparam int TCC_WGM_HI_POS = 3;
    localparam int TCC_OVF_POS = 0;
    localparam int TCC_PRE_RST_POS = 0;

    // clock select codes
    localparam logic [2:0] TCC_CS_STOP = 3'h0;
    localparam logic [2:0] TCC_CS_SYS = 3'h1;
    localparam logic [2:0] TCC_CS_DIV8 = 3'h2;
    localparam logic [2:0] TCC_CS_DIV64 = 3'h3;
    localparam logic [2:0] TCC_CS_DIV256 = 3'h4;
    localparam logic [2:0] TCC_CS_DIV1024 = 3'h5;
    localparam logic [2:0] TCC_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] TCC_CS_EXT_RISE = 3'h7;

    // prescaler taps: tick when all masked bits are one
    localparam logic [9:0] TCC_TAP8 = 10'h007;
    localparam logic [9:0] TCC_TAP64 = 10'h03F;
    localparam logic [9:0] TCC_TAP256 = 10'h0FF;
    localparam logic [9:0] TCC_TAP1024 = 10'h3FF;

    // reset values
    localparam logic [15:0] TCC_COUNT_RST = 16'h0000;
    localparam logic [7:0] TCC_LATCH_RST = 8'h00;
    localparam logic [2:0] TCC_CS_RST = 3'h0;
    localparam logic [3:0] TCC_WGM_RST = 4'h0;
    localparam logic [9:0] TCC_PRE_RST = 10'h000;

    // counter limits
    localparam logic [15:0] TCC_BOTTOM = 16'h0000;
    localparam logic [15:0] TCC_MAX = 16'hFFFF;
    localparam logic [15:0] TCC_TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TCC_TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TCC_TOP_10BIT = 16'h03FF;

    typedef enum logic [3:0] {
        TCC_K_NORMAL = 4'h1,
        TCC_K_CLEAR = 4'h2,
        TCC_K_FAST = 4'h4,
        TCC_K_DUAL = 4'h8
    } tcc_kind_t;

    typedef enum logic [1:0] {
        TCC_BUS_IDLE = 2'h1,
        TCC_BUS_ACCESS = 2'h2
    } tcc_bus_t;

    // count sequence for each waveform mode
    function automatic tcc_kind_t tcc_kind(input logic [3:0] mode);
        case (mode)
            4'h4, 4'hC: tcc_kind = TCC_K_CLEAR;
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF: tcc_kind = TCC_K_FAST;
            4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: tcc_kind = TCC_K_DUAL;
            default: tcc_kind = TCC_K_NORMAL;
        endcase
    endfunction : tcc_kind

    // modes whose top comes from the capture register
    function automatic logic tcc_top_is_capt(input logic [3:0] mode);
        tcc_top_is_capt = (mode == 4'h8) || (mode == 4'hA) ||
                          (mode == 4'hC) || (mode == 4'hE);
    endfunction : tcc_top_is_capt

    function automatic logic [15:0] tcc_top(input logic [3:0] mode,
                                            input logic [15:0] cmpa,
                                            input logic [15:0] capt);
        case (mode)
            4'h1, 4'h5: tcc_top = TCC_TOP_8BIT;
            4'h2, 4'h6: tcc_top = TCC_TOP_9BIT;
            4'h3, 4'h7: tcc_top = TCC_TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: tcc_top = cmpa;
            4'h8, 4'hA, 4'hC, 4'hE: tcc_top = capt;
            default: tcc_top = TCC_MAX;
        endcase
    endfunction : tcc_top

endpackage : tcc_pkg

// File: hdl/tcc_timer.sv
// timer clock select, prescaler, counter and 16-bit access over ahb-lite
//
// Notes on behaviour
// - one shared high-byte latch for the count, compare and capture registers
// - low-byte write loads latch plus low byte
// - count and capture low-byte reads copy high byte into latch
// - compare reads bypass and keep the latch
// - clock select zero stops ticks
// - clock select one ticks every cycle
// - codes two to five pick prescaler taps
// - prescaler runs freely of clock select
// - prescaler reset restarts the divider chain
// - external pin sampled by rising-edge synchroniser
// - codes seven and six tick rise, fall
// - pin edge reaches counter within few cycles
// - external ticks bypass the prescaler
// - tick clears or steps counter, flags top/bottom
// - counter readable and writable at any time
// - cpu write beats clear and count
// - four-bit mode split over control a/b
// - overflow flag set at mode point
// - top from compare a, capture or fixed
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
module tcc_timer
    import tcc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // timer pins and controls
    input wire logic external_count_pin,
    input wire logic timer_power_off_bit,
    // status
    output logic overflow_flag,
    output logic count_at_top,
    output logic count_at_bottom
);
    tcc_bus_t bus_state_r;
    tcc_kind_t kind;
    logic [7:0] addr_r, latch_r, wbyte, rd_byte;
    logic [31:0] hrdata_r;
    logic [15:0] timer_count_r, cmpa_r, cmpb_r, capture_value_r;
    logic [15:0] top, step_nxt;
    logic [2:0] clock_select_field_r;
    logic [3:0] waveform_mode_field_r;
    logic [9:0] pre_r;
    logic wr_q_r, hreadyout_r, hresp_r, dir_up_r;
    logic overflow_flag_r, at_top_r, at_bottom_r;
    logic accept, wr_en, rd_en, wr_cnt_lo, rd_cnt_lo, rd_capt_lo;
    logic wr_any_hi, pre_clear, flag_clear, ext_rise, ext_fall;
    logic tick_raw, timer_tick, dir_nxt, ovf_evt, ovf_set;
    default clocking cb_sys @(posedge clk);
    endclocking
    default disable iff (!resetn);
    function automatic logic tap_hit(input logic [9:0] pre,
                                     input logic [9:0] mask);
        tap_hit = (pre & mask) == mask;
    endfunction : tap_hit
    // bus front end: one wait state per transfer
    assign accept = hsel && htrans[1] && hready &&
                    (bus_state_r == TCC_BUS_IDLE);
    assign wr_en = (bus_state_r == TCC_BUS_ACCESS) && wr_q_r;
    assign rd_en = (bus_state_r == TCC_BUS_ACCESS) && !wr_q_r;
    assign wbyte = hwdata[7:0];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_state_r <= TCC_BUS_IDLE;
            addr_r <= 8'h00;
            wr_q_r <= 1'b0;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            hresp_r <= 1'b0;
            unique case (bus_state_r)
                TCC_BUS_IDLE: begin
                    if (accept) begin
                        addr_r <= haddr[7:0];
                        wr_q_r <= hwrite;
                        hreadyout_r <= 1'b0;
                        bus_state_r <= TCC_BUS_ACCESS;
                    end
                end
                TCC_BUS_ACCESS: begin
                    hreadyout_r <= 1'b1;
                    bus_state_r <= TCC_BUS_IDLE;
                end
            endcase
        end
    end
    // access decode
    assign wr_cnt_lo = wr_en && (addr_r == TCC_OFF_COUNT_LO);
    assign rd_cnt_lo = rd_en && (addr_r == TCC_OFF_COUNT_LO);
    assign rd_capt_lo = rd_en && (addr_r == TCC_OFF_CAPT_LO);
    assign wr_any_hi = wr_en && ((addr_r == TCC_OFF_COUNT_HI) ||
                       (addr_r == TCC_OFF_CMPA_HI) ||
                       (addr_r == TCC_OFF_CMPB_HI) ||
                       (addr_r == TCC_OFF_CAPT_HI));
    assign pre_clear = wr_en && (addr_r == TCC_OFF_PRESCALE) &&
                       wbyte[TCC_PRE_RST_POS];
    assign flag_clear = wr_en && (addr_r == TCC_OFF_FLAGS) &&
                        wbyte[TCC_OVF_POS];
    // shared high-byte latch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latch_r <= TCC_LATCH_RST;
        end else if (wr_any_hi) begin
            latch_r <= wbyte;
        end else if (rd_cnt_lo) begin
            latch_r <= timer_count_r[15:8];
        end else if (rd_capt_lo) begin
            latch_r <= capture_value_r[15:8];
        end
    end
    // control registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clock_select_field_r <= TCC_CS_RST;
            waveform_mode_field_r <= TCC_WGM_RST;
        end else if (wr_en && addr_r == TCC_OFF_CTRL_B) begin
            clock_select_field_r <= wbyte[TCC_CS_POS +: 3];
            waveform_mode_field_r[3:2] <= wbyte[TCC_WGM_HI_POS +: 2];
        end else if (wr_en && addr_r == TCC_OFF_CTRL_A) begin
            waveform_mode_field_r[1:0] <= wbyte[TCC_WGM_LO_POS +: 2];
        end
    end
    // compare and capture registers, loaded whole on low-byte write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmpa_r <= TCC_COUNT_RST;
            cmpb_r <= TCC_COUNT_RST;
            capture_value_r <= TCC_COUNT_RST;
        end else if (wr_en) begin
            if (addr_r == TCC_OFF_CMPA_LO) begin
                cmpa_r <= {latch_r, wbyte};
            end
            if (addr_r == TCC_OFF_CMPB_LO) begin
                cmpb_r <= {latch_r, wbyte};
            end
            // writable only while it defines top
            if (addr_r == TCC_OFF_CAPT_LO &&
                tcc_top_is_capt(waveform_mode_field_r)) begin
                capture_value_r <= {latch_r, wbyte};
            end
        end
    end
    // free-running prescaler
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pre_r <= TCC_PRE_RST;
        end else if (pre_clear) begin
            pre_r <= TCC_PRE_RST;
        end else if (!timer_power_off_bit) begin
            pre_r <= pre_r + 10'h001;
        end
    end
    tcc_pin_edge u_tcc_pin_edge (
        .clk(clk),
        .resetn(resetn),
        .pin(external_count_pin),
        .rise(ext_rise),
        .fall(ext_fall)
    );
    // clock select
    always_comb begin
        tick_raw = 1'b0;
        unique case (clock_select_field_r)
            TCC_CS_STOP: tick_raw = 1'b0;
            TCC_CS_SYS: tick_raw = 1'b1;
            TCC_CS_DIV8: tick_raw = tap_hit(pre_r, TCC_TAP8);
            TCC_CS_DIV64: tick_raw = tap_hit(pre_r, TCC_TAP64);
            TCC_CS_DIV256: tick_raw = tap_hit(pre_r, TCC_TAP256);
            TCC_CS_DIV1024: tick_raw = tap_hit(pre_r, TCC_TAP1024);
            TCC_CS_EXT_FALL: tick_raw = ext_fall;
            TCC_CS_EXT_RISE: tick_raw = ext_rise;
        endcase
    end
    assign timer_tick = tick_raw && !timer_power_off_bit;
    // count sequence
    assign kind = tcc_kind(waveform_mode_field_r);
    assign top = tcc_top(waveform_mode_field_r, cmpa_r,
                         capture_value_r);

    always_comb begin
        step_nxt = timer_count_r + 16'h0001;
        dir_nxt = 1'b1;
        ovf_evt = 1'b0;
        unique case (kind)
            TCC_K_NORMAL: begin
                ovf_evt = (timer_count_r == TCC_MAX);
            end
            TCC_K_CLEAR: begin
                if (timer_count_r == top) begin
                    step_nxt = TCC_BOTTOM;
                end
                ovf_evt = (timer_count_r == TCC_MAX);
            end
            TCC_K_FAST: begin
                if (timer_count_r == top) begin
                    step_nxt = TCC_BOTTOM;
                    ovf_evt = 1'b1;
                end
            end
            TCC_K_DUAL: begin
                dir_nxt = dir_up_r;
                if (dir_up_r) begin
                    if (timer_count_r >= top) begin
                        dir_nxt = 1'b0;
                        step_nxt = timer_count_r - 16'h0001;
                    end
                end else if (timer_count_r == TCC_BOTTOM) begin
                    dir_nxt = 1'b1;
                    ovf_evt = 1'b1;
                end else begin
                    step_nxt = timer_count_r - 16'h0001;
                end
            end
        endcase
    end
    assign ovf_set = timer_tick && ovf_evt && !wr_cnt_lo;
    // counter: cpu write first, then tick
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timer_count_r <= TCC_COUNT_RST;
            dir_up_r <= 1'b1;
        end else if (wr_cnt_lo) begin
            timer_count_r <= {latch_r, wbyte};
        end else if (timer_tick) begin
            timer_count_r <= step_nxt;
            dir_up_r <= dir_nxt;
        end
    end
    // overflow flag: write one clears, a new event wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            overflow_flag_r <= 1'b0;
        end else if (ovf_set) begin
            overflow_flag_r <= 1'b1;
        end else if (flag_clear) begin
            overflow_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            at_top_r <= 1'b0;
            at_bottom_r <= 1'b0;
        end else begin
            at_top_r <= (timer_count_r == top);
            at_bottom_r <= (timer_count_r == TCC_BOTTOM);
        end
    end
    // read mux
    always_comb begin
        rd_byte = 8'h00;
        unique case (addr_r)
            TCC_OFF_CTRL_A: rd_byte = {6'h00, waveform_mode_field_r[1:0]};
            TCC_OFF_CTRL_B: rd_byte = {3'h0, waveform_mode_field_r[3:2],
                                       clock_select_field_r};
            TCC_OFF_COUNT_LO: rd_byte = timer_count_r[7:0];
            TCC_OFF_COUNT_HI: rd_byte = latch_r;
            TCC_OFF_CMPA_LO: rd_byte = cmpa_r[7:0];
            TCC_OFF_CMPA_HI: rd_byte = cmpa_r[15:8];
            TCC_OFF_CMPB_LO: rd_byte = cmpb_r[7:0];
            TCC_OFF_CMPB_HI: rd_byte = cmpb_r[15:8];
            TCC_OFF_CAPT_LO: rd_byte = capture_value_r[7:0];
            TCC_OFF_CAPT_HI: rd_byte = latch_r;
            TCC_OFF_FLAGS: rd_byte = {7'h00, overflow_flag_r};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_en) begin
            hrdata_r <= {24'h00_0000, rd_byte};
        end
    end

    assign hreadyout = hreadyout_r;
    assign hrdata = hrdata_r;
    assign hresp = hresp_r;
    assign overflow_flag = overflow_flag_r;
    assign count_at_top = at_top_r;
    assign count_at_bottom = at_bottom_r;

    // checks
    property p_stop;
        (clock_select_field_r == TCC_CS_STOP && !wr_cnt_lo)
            |=> $stable(timer_count_r);
    endproperty
    a_stop: assert property (p_stop)
        else $error("counter moved while stopped");
    property p_sys;
        (clock_select_field_r == TCC_CS_SYS && !timer_power_off_bit &&
         !wr_cnt_lo && kind != TCC_K_DUAL && top != TCC_BOTTOM)
            |=> timer_count_r != $past(timer_count_r);
    endproperty
    a_sys: assert property (p_sys)
        else $error("counter idle at system rate");
    property p_div8;
        (timer_tick && clock_select_field_r == TCC_CS_DIV8)
            |-> pre_r[2:0] == 3'h7;
    endproperty
    a_div8: assert property (p_div8)
        else $error("divide by 8 tick off tap");
    property p_pre_clear;
        pre_clear |=> pre_r == TCC_PRE_RST;
    endproperty
    a_pre_clear: assert property (p_pre_clear)
        else $error("prescaler not restarted");
    property p_ext_rise;
        ($rose(external_count_pin) && !timer_power_off_bit &&
         clock_select_field_r == TCC_CS_EXT_RISE)
            |-> ##2 timer_tick;
    endproperty
    a_ext_rise: assert property (p_ext_rise)
        else $error("pin edge tick late");
    property p_low_write;
        wr_cnt_lo |=> timer_count_r == {$past(latch_r), $past(wbyte)};
    endproperty
    a_low_write: assert property (p_low_write)
        else $error("counter write lost");
    property p_low_read;
        rd_cnt_lo |=> {8'h00, latch_r} == ($past(timer_count_r) >> 8);
    endproperty
    a_low_read: assert property (p_low_read)
        else $error("latch not loaded on low read");
    property p_cmp_read;
        (rd_en && (addr_r == TCC_OFF_CMPA_LO || addr_r == TCC_OFF_CMPA_HI ||
                   addr_r == TCC_OFF_CMPB_LO || addr_r == TCC_OFF_CMPB_HI))
            |=> $stable(latch_r);
    endproperty
    a_cmp_read: assert property (p_cmp_read)
        else $error("compare read touched latch");
    property p_ovf;
        ovf_set |=> overflow_flag_r;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow flag not set");
    property p_normal_step;
        (timer_tick && !wr_cnt_lo && kind == TCC_K_NORMAL)
            |=> timer_count_r == $past(timer_count_r) + 16'h0001;
    endproperty
    a_normal_step: assert property (p_normal_step)
        else $error("normal mode step wrong");
endmodule : tcc_timer

// File: verification/tcc_cpu_model.sv
// ahb-lite master standing in for the cpu core
module tcc_cpu_model (
    // clock
    input wire logic clk,
    // ahb-lite master side
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end
    // one word transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata[7:0];
        // released data lines do not keep the last value
        hwdata <= ~hwdata;
    endtask : xfer
    // whole values, never split by another access
    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        logic [7:0] q;
        xfer(1'b1, lo + 8'h04, v[15:8], q);
        xfer(1'b1, lo, v[7:0], q);
    endtask : wr16
    task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
        xfer(1'b0, lo, 8'h00, v[7:0]);
        xfer(1'b0, lo + 8'h04, 8'h00, v[15:8]);
    endtask : rd16
endmodule : tcc_cpu_model

// File: verification/test_tcc_timer.sv
// self-checking bench for the timer clock and counter core
module test_tcc_timer
    import tcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, resetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic external_count_pin, timer_power_off_bit;
    logic overflow_flag, count_at_top, count_at_bottom;
    logic [15:0] v0, v1;
    int n_mismatch = 0;
    int samples_checked = 0;
    tcc_timer u_tcc_timer (
        .clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
        .external_count_pin, .timer_power_off_bit, .overflow_flag,
        .count_at_top, .count_at_bottom
    );
    tcc_cpu_model u_tcc_cpu_model (
        .clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata
    );
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #300_000;
        n_mismatch++;
        end_of_test();
    end
    task automatic end_of_test();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_tcc_cpu_model.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        u_tcc_cpu_model.xfer(1'b0, a, 8'h00, q);
        chk({8'h00, q}, {8'h00, exp});
    endtask : rdc
    task automatic r16(output logic [15:0] v);
        u_tcc_cpu_model.rd16(TCC_OFF_COUNT_LO, v);
    endtask : r16
    // pin half periods of three cycles
    task automatic pulse();
        external_count_pin <= 1'b1;
        repeat (3) @(posedge clk);
        external_count_pin <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse
    task automatic t_reset();
        rdc(TCC_OFF_COUNT_LO, 8'h00);
        rdc(TCC_OFF_COUNT_HI, 8'h00);
        rdc(TCC_OFF_CTRL_B, 8'h00);
        chk({15'h0000, count_at_bottom}, 16'h0001);
        chk({15'h0000, hresp}, 16'h0000);
        wr(8'h30, 8'hA5);
        rdc(8'h30, 8'h00);
    endtask : t_reset
    task automatic t_latch();
        u_tcc_cpu_model.wr16(TCC_OFF_COUNT_LO, 16'h1234);
        u_tcc_cpu_model.wr16(TCC_OFF_CMPA_LO, 16'h5678);
        rdc(TCC_OFF_COUNT_LO, 8'h34);
        rdc(TCC_OFF_CMPA_HI, 8'h56);
        rdc(TCC_OFF_CMPA_LO, 8'h78);
        rdc(TCC_OFF_COUNT_HI, 8'h12);
        wr(TCC_OFF_CMPA_HI, 8'h9A);
        wr(TCC_OFF_CMPA_LO, 8'h11);
        wr(TCC_OFF_CMPB_LO, 8'h22);
        rdc(TCC_OFF_CMPB_HI, 8'h9A);
        rdc(TCC_OFF_CMPA_HI, 8'h9A);
    endtask : t_latch
    // exact window of 1024 cycles between the two low-byte reads
    task automatic t_rates();
        int divs[5] = '{1, 8, 64, 256, 1024};
        for (int i = 0; i < 5; i++) begin
            wr(TCC_OFF_CTRL_B, 8'(i + 1));
            r16(v0);
            repeat (1018) @(posedge clk);
            r16(v1);
            chk(v1 - v0, 16'(1024 / divs[i]));
        end
        wr(TCC_OFF_PRESCALE, 8'h01);
        r16(v0);
        repeat (1014) @(posedge clk);
        rdc(TCC_OFF_COUNT_LO, v0[7:0]);
        rdc(TCC_OFF_COUNT_LO, v0[7:0] + 8'h01);
    endtask : t_rates
    task automatic t_prio();
        wr(TCC_OFF_CTRL_B, 8'h01);
        u_tcc_cpu_model.wr16(TCC_OFF_COUNT_LO, 16'h0010);
        rdc(TCC_OFF_COUNT_LO, 8'h12);
        wr(TCC_OFF_FLAGS, 8'h01);
        u_tcc_cpu_model.wr16(TCC_OFF_COUNT_LO, 16'hFFFE);
        rdc(TCC_OFF_FLAGS, 8'h01);
        wr(TCC_OFF_FLAGS, 8'h01);
        rdc(TCC_OFF_FLAGS, 8'h00);
    endtask : t_prio
    task automatic t_ext();
        wr(TCC_OFF_CTRL_B, 8'h00);
        u_tcc_cpu_model.wr16(TCC_OFF_COUNT_LO, 16'h0000);
        wr(TCC_OFF_CTRL_B, {5'h00, TCC_CS_EXT_RISE});
        repeat (5) pulse();
        r16(v0);
        chk(v0, 16'h0005);
        external_count_pin <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(TCC_OFF_COUNT_LO, 8'h06);
        wr(TCC_OFF_CTRL_B, {5'h00, TCC_CS_EXT_FALL});
        external_count_pin <= 1'b0;
        repeat (3) @(posedge clk);
        rdc(TCC_OFF_COUNT_LO, 8'h07);
        pulse();
        rdc(TCC_OFF_COUNT_LO, 8'h08);
    endtask : t_ext
    // fast mode 15: top from compare a, counts 0..5
    task automatic t_mode();
        wr(TCC_OFF_CTRL_B, 8'h00);
        u_tcc_cpu_model.wr16(TCC_OFF_CMPA_LO, 16'h0005);
        u_tcc_cpu_model.wr16(TCC_OFF_COUNT_LO, 16'h0000);
        wr(TCC_OFF_FLAGS, 8'h01);
        wr(TCC_OFF_CTRL_A, 8'h03);
        wr(TCC_OFF_CTRL_B, 8'h19);
        rdc(TCC_OFF_COUNT_LO, 8'h02);
        rdc(TCC_OFF_COUNT_LO, 8'h05);
        chk({15'h0000, count_at_top}, 16'h0001);
        rdc(TCC_OFF_COUNT_LO, 8'h02);
        rdc(TCC_OFF_FLAGS, 8'h01);
        chk({15'h0000, overflow_flag}, 16'h0001);
    endtask : t_mode
    initial begin
        resetn = 1'b0;
        external_count_pin = 1'b0;
        timer_power_off_bit = 1'b1;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        timer_power_off_bit <= 1'b0;
        @(posedge clk);
        t_reset();
        t_latch();
        t_rates();
        t_prio();
        t_ext();
        t_mode();
        end_of_test();
    end
endmodule : test_tcc_timer
